// ===== hdl/cab_exec_core.sv
// Execution core of the 8-bit processor: ALU, branches, skips, I/O access, APB slave
// Behaviour
// - Register add, optional carry, one cycle
// - Word add/subtract immediate in two cycles
// - Subtract register or constant, optional carry
// - AND, OR, XOR update Z, N, V, S only
// - Set bits by OR mask, one cycle
// - Clear bits by AND with 0xFF minus mask
// - Test register by AND with itself
// - Indirect jump from pointer pair, two cycles
// - Relative call to counter plus offset plus one
// - Indirect call from pointer pair, three cycles
// - Direct call in four cycles, flags kept
// - Compare, skip next if equal
// - Compare without writeback, six flags updated
// - Skip on working register bit clear/set
// - Skip on I/O register bit clear/set
// - Branch on chosen flag, one/two cycles
// - Bit operations only on I/O 0x00-0x1F
// - Bit set/clear touches only addressed bit
// - I/O 0x00-0x3F, data space adds 0x20
// - Extended I/O only by load/store
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "cab_consts.svh"
module cab_exec_core
  import cab_pkg::*;
#(
  parameter int STACK_DEPTH = 16,
  parameter int STACK_AW    = 4
)
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output wire logic [31:0] prdata,
  output wire logic        pready,
  output wire logic        pslverr,
  output wire logic [7:0]  ioAddr,
  output wire logic [7:0]  ioWrData,
  output wire logic [7:0]  ioWrMask,
  output wire logic        ioWrEn,
  output wire logic        ioRdEn,
  input  wire logic [7:0]  ioRdData
);

  cab_state_type        state_reg;
  logic [31:0]          instr_reg;
  logic [15:0]          target_reg;
  logic [15:0]          programCounter_reg;
  logic [7:0]           statusFlags_reg;
  logic [4:0]           regSel_reg;
  logic [2:0]           wait_reg;
  logic                 refused_reg;
  logic                 ioBad_reg;
  logic [31:0]          prdata_reg;
  logic                 pready_reg;
  logic                 pslverr_reg;
  logic [7:0]           ioAddr_reg;
  logic [7:0]           ioWrData_reg;
  logic [7:0]           ioWrMask_reg;
  logic                 ioWrEn_reg;
  logic                 ioRdEn_reg;
  logic [7:0]           regFile [0:31];
  logic [15:0]          stack [0:STACK_DEPTH-1];
  logic [STACK_AW-1:0]  stackPtr_reg;

  logic                 busy;
  logic                 mapped;
  logic                 apbWr;
  logic                 apbOk;
  logic                 start;
  logic                 exec;
  logic [31:0]          rdMux;

  cab_op_type           op;
  logic [4:0]           dIdx;
  logic [4:0]           rIdx;
  logic [7:0]           imm;
  logic [2:0]           bitSel;
  logic [7:0]           rd;
  logic [7:0]           rr;
  logic [7:0]           opB;
  logic                 useImm;
  logic                 useCarry;
  logic                 carryIn;
  logic [8:0]           sum9;
  logic [8:0]           dif9;
  logic                 addH;
  logic                 addV;
  logic                 subH;
  logic                 subV;
  logic [4:0]           pairLo;
  logic [4:0]           pairHi;
  logic [15:0]          wordIn;
  logic [15:0]          wordAdd;
  logic [15:0]          wordSub;
  logic [15:0]          pcInc;
  logic [15:0]          pcRel;
  logic [15:0]          ptrZ;

  logic [7:0]           res;
  logic [15:0]          wordRes;
  logic [4:0]           wrIdx;
  logic                 wrEn;
  logic                 wrWord;
  logic                 setZN;
  logic                 keepZ;
  logic                 skip;
  logic [7:0]           flg;
  logic [15:0]          pcNext;
  logic [2:0]           cycles;
  logic                 push;
  logic                 pop;
  logic [15:0]          pushVal;

  cab_op_type           nOp;
  logic [7:0]           nAddr;
  logic [7:0]           ioAddr_next;
  logic [7:0]           ioWrData_next;
  logic [7:0]           ioWrMask_next;
  logic                 ioWrEn_next;
  logic                 ioRdEn_next;
  logic                 ioBad_next;

  assign prdata   = prdata_reg;
  assign pready   = pready_reg;
  assign pslverr  = pslverr_reg;
  assign ioAddr   = ioAddr_reg;
  assign ioWrData = ioWrData_reg;
  assign ioWrMask = ioWrMask_reg;
  assign ioWrEn   = ioWrEn_reg;
  assign ioRdEn   = ioRdEn_reg;

  // APB decode; one wait state so read data always comes from a flop
  assign busy   = state_reg != S_IDLE;
  assign mapped = paddr inside {`CAB_A_INSTR, `CAB_A_TARGET, `CAB_A_PC, `CAB_A_FLAGS,
                                `CAB_A_STATUS, `CAB_A_REGSEL, `CAB_A_REGDATA};
  assign apbWr  = psel & penable & pwrite & pready_reg;
  assign apbOk  = apbWr & mapped & ~busy;
  assign start  = apbOk & (paddr == `CAB_A_INSTR);
  assign exec   = state_reg == S_EXEC;

  always_comb
  begin
    rdMux = 32'h0000_0000;
    case (paddr)
      `CAB_A_INSTR:   rdMux = instr_reg;
      `CAB_A_TARGET:  rdMux[15:0] = target_reg;
      `CAB_A_PC:      rdMux[15:0] = programCounter_reg;
      `CAB_A_FLAGS:   rdMux[7:0] = statusFlags_reg;
      `CAB_A_STATUS:
      begin
        rdMux[`CAB_STAT_BUSY] = busy;
        rdMux[`CAB_STAT_REFUSE] = refused_reg;
        rdMux[`CAB_STAT_SP_LSB +: STACK_AW] = stackPtr_reg;
      end
      `CAB_A_REGSEL:  rdMux[4:0] = regSel_reg;
      `CAB_A_REGDATA: rdMux[7:0] = regFile[regSel_reg];
      default:        rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg  <= psel & penable & ~pready_reg;
      pslverr_reg <= psel & penable & ~pready_reg & ~mapped;
      if (psel & penable & ~pready_reg)
      begin
        prdata_reg <= pwrite ? 32'h0000_0000 : rdMux;
      end
    end
  end

  // Instruction fields
  assign op       = cab_op_type'(instr_reg[`CAB_F_OP]);
  assign dIdx     = instr_reg[`CAB_F_D];
  assign rIdx     = instr_reg[`CAB_F_R];
  assign imm      = instr_reg[`CAB_F_IMM];
  assign bitSel   = instr_reg[`CAB_F_BIT];
  assign rd       = regFile[dIdx];
  assign rr       = regFile[rIdx];
  assign useImm   = op inside {OP_SUBTRACT_IMMEDIATE, OP_SUBTRACT_WITH_CARRY_IMMEDIATE,
                               OP_AND_IMMEDIATE, OP_OR_IMMEDIATE, OP_COMPARE_IMMEDIATE};
  assign useCarry = op inside {OP_ADD_CARRY, OP_SUBTRACT_WITH_CARRY,
                               OP_SUBTRACT_WITH_CARRY_IMMEDIATE, OP_COMPARE_WITH_CARRY};
  assign opB      = useImm ? imm : rr;
  assign carryIn  = statusFlags_reg[`CAB_FL_C] & useCarry;
  assign sum9     = {1'b0, rd} + {1'b0, opB} + {8'h00, carryIn};
  assign dif9     = {1'b0, rd} - {1'b0, opB} - {8'h00, carryIn};
  assign addH     = rd[3] & opB[3] | opB[3] & ~sum9[3] | ~sum9[3] & rd[3];
  assign addV     = rd[7] & opB[7] & ~sum9[7] | ~rd[7] & ~opB[7] & sum9[7];
  assign subH     = ~rd[3] & opB[3] | opB[3] & dif9[3] | dif9[3] & ~rd[3];
  assign subV     = rd[7] & ~opB[7] & ~dif9[7] | ~rd[7] & opB[7] & dif9[7];
  // Word ops always use an even-aligned pair
  assign pairLo   = {dIdx[4:1], 1'b0};
  assign pairHi   = {dIdx[4:1], 1'b1};
  assign wordIn   = {regFile[pairHi], regFile[pairLo]};
  assign wordAdd  = wordIn + {10'h000, instr_reg[`CAB_F_K6]};
  assign wordSub  = wordIn - {10'h000, instr_reg[`CAB_F_K6]};
  assign pcInc    = programCounter_reg + `CAB_PC_STEP;
  assign pcRel    = programCounter_reg + {{8{imm[7]}}, imm} + `CAB_PC_STEP;
  assign ptrZ     = {regFile[`CAB_PTR_HI], regFile[`CAB_PTR_LO]};

  always_comb
  begin
    res     = rd;
    wordRes = wordAdd;
    wrIdx   = dIdx;
    wrEn    = 1'b0;
    wrWord  = 1'b0;
    setZN   = 1'b0;
    keepZ   = 1'b0;
    skip    = 1'b0;
    flg     = statusFlags_reg;
    pcNext  = pcInc;
    cycles  = `CAB_CYC_ONE;
    push    = 1'b0;
    pop     = 1'b0;
    pushVal = pcInc;
    case (op)
      OP_ADD, OP_ADD_CARRY:
      begin
        res = sum9[7:0];
        wrEn = 1'b1;
        setZN = 1'b1;
        flg[`CAB_FL_C] = sum9[8];
        flg[`CAB_FL_H] = addH;
        flg[`CAB_FL_V] = addV;
      end
      OP_SUB, OP_SUBTRACT_IMMEDIATE, OP_SUBTRACT_WITH_CARRY, OP_SUBTRACT_WITH_CARRY_IMMEDIATE,
      OP_COMPARE, OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE:
      begin
        res = dif9[7:0];
        wrEn = ~(op inside {OP_COMPARE, OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE});
        setZN = 1'b1;
        keepZ = useCarry;
        flg[`CAB_FL_C] = dif9[8];
        flg[`CAB_FL_H] = subH;
        flg[`CAB_FL_V] = subV;
      end
      OP_ADD_IMMEDIATE_WORD, OP_SUBTRACT_IMMEDIATE_WORD:
      begin
        wrWord = 1'b1;
        cycles = `CAB_CYC_TWO;
        if (op == OP_ADD_IMMEDIATE_WORD)
        begin
          wordRes = wordAdd;
          flg[`CAB_FL_V] = ~wordIn[15] & wordAdd[15];
          flg[`CAB_FL_C] = ~wordAdd[15] & wordIn[15];
        end
        else
        begin
          wordRes = wordSub;
          flg[`CAB_FL_V] = wordIn[15] & ~wordSub[15];
          flg[`CAB_FL_C] = wordSub[15] & ~wordIn[15];
        end
        flg[`CAB_FL_Z] = wordRes == 16'h0000;
        flg[`CAB_FL_N] = wordRes[15];
        flg[`CAB_FL_S] = wordRes[15] ^ flg[`CAB_FL_V];
      end
      OP_AND, OP_AND_IMMEDIATE, OP_OR, OP_OR_IMMEDIATE, OP_EXCLUSIVE_OR, OP_SET_BITS_MASK,
      OP_CLEAR_BITS_MASK, OP_ZERO_SIGN_CHECK, OP_REGISTER_ZEROING:
      begin
        case (op)
          OP_AND, OP_AND_IMMEDIATE: res = rd & opB;
          OP_OR, OP_OR_IMMEDIATE:   res = rd | opB;
          OP_EXCLUSIVE_OR:          res = rd ^ rr;
          OP_SET_BITS_MASK:         res = rd | imm;
          OP_CLEAR_BITS_MASK:       res = rd & (`CAB_FULL8 - imm);
          OP_ZERO_SIGN_CHECK:       res = rd & rd;
          default:                  res = rd ^ rd;
        endcase
        wrEn = op != OP_ZERO_SIGN_CHECK;
        setZN = 1'b1;
        flg[`CAB_FL_V] = 1'b0;
      end
      OP_ONES_INVERT:
      begin
        res = `CAB_FULL8 - rd;
        wrEn = 1'b1;
        setZN = 1'b1;
        flg[`CAB_FL_C] = 1'b1;
        flg[`CAB_FL_V] = 1'b0;
      end
      OP_ARITH_INVERSE:
      begin
        res = `CAB_ZERO8 - rd;
        wrEn = 1'b1;
        setZN = 1'b1;
        flg[`CAB_FL_C] = res != `CAB_ZERO8;
        flg[`CAB_FL_V] = res == `CAB_MIN_NEG;
        flg[`CAB_FL_H] = res[3] | rd[3];
      end
      OP_INCREMENT, OP_MINUS_ONE:
      begin
        res = (op == OP_INCREMENT) ? rd + `CAB_BIT0 : rd - `CAB_BIT0;
        wrEn = 1'b1;
        setZN = 1'b1;
        flg[`CAB_FL_V] = res == ((op == OP_INCREMENT) ? `CAB_MIN_NEG : `CAB_MAX_POS);
      end
      OP_REGISTER_ALL_ONES:
      begin
        res = `CAB_FULL8;
        wrEn = 1'b1;
      end
      OP_RELATIVE_JUMP:
      begin
        pcNext = pcRel;
        cycles = `CAB_CYC_TWO;
      end
      OP_INDIRECT_JUMP:
      begin
        pcNext = ptrZ;
        cycles = `CAB_CYC_TWO;
      end
      OP_DIRECT_JUMP:
      begin
        pcNext = target_reg;
        cycles = `CAB_CYC_THREE;
      end
      OP_RELATIVE_CALL, OP_INDIRECT_CALL:
      begin
        push = 1'b1;
        pcNext = (op == OP_RELATIVE_CALL) ? pcRel : ptrZ;
        cycles = `CAB_CYC_THREE;
      end
      OP_DIRECT_CALL:
      begin
        push = 1'b1;
        pushVal = programCounter_reg + `CAB_PC_SKIP_S;
        pcNext = target_reg;
        cycles = `CAB_CYC_FOUR;
      end
      OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT:
      begin
        pop = 1'b1;
        pcNext = stack[stackPtr_reg - 1'b1];
        cycles = `CAB_CYC_FOUR;
        if (op == OP_INTERRUPT_EXIT)
          flg[`CAB_FL_I] = 1'b1;
      end
      OP_COMPARE_SKIP_EQUAL:  skip = rd == rr;
      OP_SKIP_REG_BIT_CLEAR:  skip = ~rr[bitSel];
      OP_SKIP_REG_BIT_SET:    skip = rr[bitSel];
      OP_SKIP_IO_BIT_CLEAR:   skip = ~ioBad_reg & ~ioRdData[bitSel];
      OP_SKIP_IO_BIT_SET:     skip = ~ioBad_reg & ioRdData[bitSel];
      OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR:
      begin
        if (statusFlags_reg[bitSel] == (op == OP_BRANCH_FLAG_SET))
        begin
          pcNext = pcRel;
          cycles = `CAB_CYC_TWO;
        end
      end
      OP_SET_IO_BIT, OP_CLEAR_IO_BIT:
        cycles = ioBad_reg ? `CAB_CYC_ONE : `CAB_CYC_TWO;
      OP_IO_INPUT:
      begin
        res = ioRdData;
        wrEn = ~ioBad_reg;
      end
      OP_MEMORY_READ_DIRECT:
      begin
        // Low data space is the working register file itself
        res = (imm < `CAB_IO_OFS) ? regFile[imm[4:0]] : ioRdData;
        wrEn = 1'b1;
        cycles = `CAB_CYC_TWO;
      end
      OP_MEMORY_WRITE_DIRECT:
      begin
        res = rr;
        wrIdx = imm[4:0];
        wrEn = imm < `CAB_IO_OFS;
        cycles = `CAB_CYC_TWO;
      end
      default: ;
    endcase
    if (setZN)
    begin
      flg[`CAB_FL_Z] = (res == `CAB_ZERO8) & (~keepZ | statusFlags_reg[`CAB_FL_Z]);
      flg[`CAB_FL_N] = res[7];
      flg[`CAB_FL_S] = res[7] ^ flg[`CAB_FL_V];
    end
    if (skip)
    begin
      pcNext = programCounter_reg + (instr_reg[`CAB_F_LONG] ? `CAB_PC_SKIP_L : `CAB_PC_SKIP_S);
      cycles = instr_reg[`CAB_F_LONG] ? `CAB_CYC_THREE : `CAB_CYC_TWO;
    end
  end

  // I/O strobes decoded from the incoming word so they can leave a flop in the first busy cycle
  always_comb
  begin
    nOp = cab_op_type'(pwdata[`CAB_F_OP]);
    nAddr = pwdata[`CAB_F_IMM];
    ioAddr_next = nAddr + `CAB_IO_OFS;
    ioWrData_next = regFile[pwdata[`CAB_F_R]];
    ioWrMask_next = `CAB_FULL8;
    ioWrEn_next = 1'b0;
    ioRdEn_next = 1'b0;
    ioBad_next = 1'b0;
    case (nOp)
      OP_SET_IO_BIT, OP_CLEAR_IO_BIT, OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET:
      begin
        ioBad_next = nAddr > `CAB_BITIO_MAX;
        ioWrEn_next = ~ioBad_next & (nOp inside {OP_SET_IO_BIT, OP_CLEAR_IO_BIT});
        ioRdEn_next = ~ioBad_next & (nOp inside {OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET});
        // Masked write, no read-back, so write-one-to-clear flags nearby stay intact
        ioWrMask_next = `CAB_BIT0 << pwdata[`CAB_F_BIT];
        ioWrData_next = (nOp == OP_SET_IO_BIT) ? `CAB_FULL8 : `CAB_ZERO8;
      end
      OP_IO_INPUT, OP_IO_OUTPUT:
      begin
        ioBad_next = nAddr > `CAB_IO_MAX;
        ioRdEn_next = ~ioBad_next & (nOp == OP_IO_INPUT);
        ioWrEn_next = ~ioBad_next & (nOp == OP_IO_OUTPUT);
      end
      OP_MEMORY_READ_DIRECT, OP_MEMORY_WRITE_DIRECT:
      begin
        ioAddr_next = nAddr;
        ioRdEn_next = (nAddr >= `CAB_IO_OFS) & (nOp == OP_MEMORY_READ_DIRECT);
        ioWrEn_next = (nAddr >= `CAB_IO_OFS) & (nOp == OP_MEMORY_WRITE_DIRECT);
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ioAddr_reg   <= `CAB_ZERO8;
      ioWrData_reg <= `CAB_ZERO8;
      ioWrMask_reg <= `CAB_ZERO8;
      ioWrEn_reg   <= 1'b0;
      ioRdEn_reg   <= 1'b0;
      ioBad_reg    <= 1'b0;
    end
    else
    begin
      ioWrEn_reg <= start & ioWrEn_next;
      ioRdEn_reg <= start & ioRdEn_next;
      if (start)
      begin
        ioAddr_reg   <= ioAddr_next;
        ioWrData_reg <= ioWrData_next;
        ioWrMask_reg <= ioWrMask_next;
        ioBad_reg    <= ioBad_next;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= S_IDLE;
      wait_reg  <= 3'h0;
      instr_reg <= 32'h0000_0000;
    end
    else
    begin
      case (state_reg)
        S_IDLE:
        begin
          if (start)
          begin
            instr_reg <= pwdata;
            state_reg <= S_EXEC;
          end
        end
        S_EXEC:
        begin
          wait_reg  <= cycles - `CAB_WAIT_OFS;
          state_reg <= (cycles == `CAB_CYC_ONE) ? S_IDLE : S_WAIT;
        end
        S_WAIT:
        begin
          wait_reg <= wait_reg - 3'h1;
          if (wait_reg == 3'h0)
            state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      programCounter_reg <= `CAB_PC_RST;
      statusFlags_reg    <= `CAB_FLAGS_RST;
      target_reg         <= 16'h0000;
      regSel_reg         <= 5'h00;
      stackPtr_reg       <= '0;
    end
    else
    begin
      if (exec)
      begin
        programCounter_reg <= pcNext;
        statusFlags_reg    <= flg;
        if (push)
          stackPtr_reg <= stackPtr_reg + 1'b1;
        else if (pop)
          stackPtr_reg <= stackPtr_reg - 1'b1;
      end
      else if (apbOk)
      begin
        if (paddr == `CAB_A_PC)
          programCounter_reg <= pwdata[15:0];
        if (paddr == `CAB_A_FLAGS)
          statusFlags_reg <= pwdata[7:0];
      end
      if (apbOk & (paddr == `CAB_A_TARGET))
        target_reg <= pwdata[15:0];
      if (apbOk & (paddr == `CAB_A_REGSEL))
        regSel_reg <= pwdata[4:0];
    end
  end

  // Refused write or out-of-range I/O; a new refusal beats a clear in the same cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      refused_reg <= 1'b0;
    else if ((apbWr & mapped & busy & (paddr != `CAB_A_STATUS)) | (exec & ioBad_reg))
      refused_reg <= 1'b1;
    else if (apbWr & (paddr == `CAB_A_STATUS) & pwdata[`CAB_STAT_REFUSE])
      refused_reg <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (exec & push)
      stack[stackPtr_reg] <= pushVal;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < 32; i++)
        regFile[i] <= `CAB_ZERO8;
    end
    else if (exec & wrWord)
    begin
      regFile[pairLo] <= wordRes[7:0];
      regFile[pairHi] <= wordRes[15:8];
    end
    else if (exec & wrEn)
      regFile[wrIdx] <= res;
    else if (apbOk & (paddr == `CAB_A_REGDATA))
      regFile[regSel_reg] <= pwdata[7:0];
  end

endmodule

// ===== inc/cab_consts.svh
// Constants of the execution core: offsets, fields, flags, cycle counts
`ifndef CAB_CONSTS_SVH
`define CAB_CONSTS_SVH
`define CAB_A_INSTR     8'h00
`define CAB_A_TARGET    8'h04
`define CAB_A_PC        8'h08
`define CAB_A_FLAGS     8'h0C
`define CAB_A_STATUS    8'h10
`define CAB_A_REGSEL    8'h14
`define CAB_A_REGDATA   8'h18
`define CAB_F_OP        5:0
`define CAB_F_D         10:6
`define CAB_F_R         15:11
`define CAB_F_IMM       23:16
`define CAB_F_K6        21:16
`define CAB_F_BIT       26:24
`define CAB_F_LONG      27
`define CAB_FL_C        0
`define CAB_FL_Z        1
`define CAB_FL_N        2
`define CAB_FL_V        3
`define CAB_FL_S        4
`define CAB_FL_H        5
`define CAB_FL_I        7
`define CAB_STAT_BUSY   0
`define CAB_STAT_REFUSE 1
`define CAB_STAT_SP_LSB 8
`define CAB_FLAGS_RST   8'h00
`define CAB_PC_RST      16'h0000
`define CAB_BITIO_MAX   8'h1F
`define CAB_IO_MAX      8'h3F
`define CAB_IO_OFS      8'h20
`define CAB_ZERO8       8'h00
`define CAB_FULL8       8'hFF
`define CAB_MIN_NEG     8'h80
`define CAB_MAX_POS     8'h7F
`define CAB_BIT0        8'h01
`define CAB_PTR_LO      5'h1E
`define CAB_PTR_HI      5'h1F
`define CAB_PC_STEP     16'h0001
`define CAB_PC_SKIP_S   16'h0002
`define CAB_PC_SKIP_L   16'h0003
`define CAB_CYC_ONE     3'h1
`define CAB_CYC_TWO     3'h2
`define CAB_CYC_THREE   3'h3
`define CAB_CYC_FOUR    3'h4
`define CAB_WAIT_OFS    3'h2
`endif

// ===== inc/cab_pkg.sv
// Types of the execution core
package cab_pkg;
  typedef enum logic [5:0] {
    OP_ADD = 6'h00, OP_ADD_CARRY = 6'h01, OP_ADD_IMMEDIATE_WORD = 6'h02,
    OP_SUB = 6'h03, OP_SUBTRACT_IMMEDIATE = 6'h04, OP_SUBTRACT_WITH_CARRY = 6'h05,
    OP_SUBTRACT_WITH_CARRY_IMMEDIATE = 6'h06, OP_SUBTRACT_IMMEDIATE_WORD = 6'h07,
    OP_AND = 6'h08, OP_AND_IMMEDIATE = 6'h09, OP_OR = 6'h0A, OP_OR_IMMEDIATE = 6'h0B,
    OP_EXCLUSIVE_OR = 6'h0C, OP_ONES_INVERT = 6'h0D, OP_ARITH_INVERSE = 6'h0E,
    OP_SET_BITS_MASK = 6'h0F, OP_CLEAR_BITS_MASK = 6'h10, OP_INCREMENT = 6'h11,
    OP_MINUS_ONE = 6'h12, OP_ZERO_SIGN_CHECK = 6'h13, OP_REGISTER_ZEROING = 6'h14,
    OP_REGISTER_ALL_ONES = 6'h15, OP_RELATIVE_JUMP = 6'h16, OP_INDIRECT_JUMP = 6'h17,
    OP_DIRECT_JUMP = 6'h18, OP_RELATIVE_CALL = 6'h19, OP_INDIRECT_CALL = 6'h1A,
    OP_DIRECT_CALL = 6'h1B, OP_SUBROUTINE_EXIT = 6'h1C, OP_INTERRUPT_EXIT = 6'h1D,
    OP_COMPARE_SKIP_EQUAL = 6'h1E, OP_COMPARE = 6'h1F, OP_COMPARE_WITH_CARRY = 6'h20,
    OP_COMPARE_IMMEDIATE = 6'h21, OP_SKIP_REG_BIT_CLEAR = 6'h22, OP_SKIP_REG_BIT_SET = 6'h23,
    OP_SKIP_IO_BIT_CLEAR = 6'h24, OP_SKIP_IO_BIT_SET = 6'h25, OP_BRANCH_FLAG_SET = 6'h26,
    OP_BRANCH_FLAG_CLEAR = 6'h27, OP_SET_IO_BIT = 6'h28, OP_CLEAR_IO_BIT = 6'h29,
    OP_IO_INPUT = 6'h2A, OP_IO_OUTPUT = 6'h2B, OP_MEMORY_READ_DIRECT = 6'h2C,
    OP_MEMORY_WRITE_DIRECT = 6'h2D
  } cab_op_type;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_EXEC = 2'b01,
    S_WAIT = 2'b10
  } cab_state_type;
endpackage

// ===== tb/cab_exec_core_bench.sv
// Self-checking bench of the execution core
`timescale 1ns/100ps
`include "cab_consts.svh"
module cab_exec_core_bench
  import cab_pkg::*;
;
  logic        clk, resetn, psel, penable, pwrite, pready, pslverr, ioWrEn, ioRdEn, err;
  logic [7:0]  paddr, ioAddr, ioWrData, ioWrMask, ioRdData;
  logic [31:0] pwdata, prdata, rdv;
  int          nErrors, nTests;
  cab_exec_core i_dut (.clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .ioAddr, .ioWrData, .ioWrMask, .ioWrEn, .ioRdEn, .ioRdData);
  cab_io_model i_io (.clk, .ioAddr, .ioWrData, .ioWrMask, .ioWrEn, .ioRdEn, .ioRdData);
  always #4 clk = ~clk;
  function automatic logic [31:0] ins(cab_op_type o, logic [4:0] d, logic [4:0] r, logic [7:0] k,
    logic [2:0] b, logic l);
    return {4'h0, l, b, k, r, d, o};
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    nTests++;
    if (s !== e)
    begin
      nErrors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic chkr(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rdv, e);
  endtask
  task automatic setR(input logic [4:0] n, input logic [7:0] v);
    apb(1'h1, `CAB_A_REGSEL, {27'h0, n});
    apb(1'h1, `CAB_A_REGDATA, {24'h0, v});
  endtask
  task automatic exe(input logic [31:0] w);
    apb(1'h1, `CAB_A_INSTR, w);
    // Writes while busy, other than to status, are dropped, so wait for idle
    do apb(1'h0, `CAB_A_STATUS, 32'h0); while (rdv[0] !== 1'h0);
  endtask
  task automatic testDone;
    $display("tests %0d errors %0d", nTests, nErrors);
    if (nErrors == 0 && nTests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // About 40 operations of 4 to 12 cycles each
  initial
  begin
    repeat (5000) @(posedge clk);
    nErrors++;
    testDone();
  end
  initial
  begin
    {clk, resetn, psel, penable, pwrite, paddr, pwdata, nErrors, nTests} = '0;
    repeat (4) @(posedge clk);
    resetn <= 1'h1;
    @(posedge clk);
    setR(5'h1, 8'h80);
    setR(5'h2, 8'h80);
    exe(ins(OP_ADD, 5'h1, 5'h2, 8'h0, 3'h0, 1'h0));
    chkr(`CAB_A_REGDATA, 32'h80);
    apb(1'h1, `CAB_A_REGSEL, 32'h1);
    chkr(`CAB_A_REGDATA, 32'h0);
    chkr(`CAB_A_FLAGS, 32'h1B);
    setR(5'h3, 8'hF0);
    exe(ins(OP_AND_IMMEDIATE, 5'h3, 5'h0, 8'h0F, 3'h0, 1'h0));
    chkr(`CAB_A_REGDATA, 32'h0);
    chkr(`CAB_A_FLAGS, 32'h03);
    $display("alu test done");
    apb(1'h1, `CAB_A_PC, 32'h10);
    exe(ins(OP_COMPARE_SKIP_EQUAL, 5'h1, 5'h1, 8'h0, 3'h0, 1'h1));
    chkr(`CAB_A_PC, 32'h13);
    exe(ins(OP_BRANCH_FLAG_SET, 5'h0, 5'h0, 8'hFE, 3'h1, 1'h0));
    chkr(`CAB_A_PC, 32'h12);
    apb(1'h1, `CAB_A_TARGET, 32'h1234);
    exe(ins(OP_DIRECT_CALL, 5'h0, 5'h0, 8'h0, 3'h0, 1'h0));
    chkr(`CAB_A_PC, 32'h1234);
    chkr(`CAB_A_FLAGS, 32'h03);
    chkr(`CAB_A_STATUS, 32'h100);
    exe(ins(OP_SUBROUTINE_EXIT, 5'h0, 5'h0, 8'h0, 3'h0, 1'h0));
    chkr(`CAB_A_PC, 32'h14);
    $display("flow test done");
    exe(ins(OP_CLEAR_IO_BIT, 5'h0, 5'h0, 8'h05, 3'h0, 1'h0));
    chk(i_io.mem[8'h25], 32'h24);
    exe(ins(OP_SKIP_IO_BIT_CLEAR, 5'h0, 5'h0, 8'h05, 3'h0, 1'h0));
    chkr(`CAB_A_PC, 32'h17);
    exe(ins(OP_SET_IO_BIT, 5'h0, 5'h0, 8'h20, 3'h0, 1'h0));
    chkr(`CAB_A_STATUS, 32'h2);
    chk(i_io.mem[8'h40], 32'h40);
    apb(1'h1, `CAB_A_STATUS, 32'h2);
    exe(ins(OP_IO_INPUT, 5'h4, 5'h0, 8'h3F, 3'h0, 1'h0));
    exe(ins(OP_IO_INPUT, 5'h5, 5'h0, 8'h40, 3'h0, 1'h0));
    chkr(`CAB_A_STATUS, 32'h2);
    apb(1'h1, `CAB_A_REGSEL, 32'h4);
    chkr(`CAB_A_REGDATA, 32'h5F);
    exe(ins(OP_MEMORY_READ_DIRECT, 5'h5, 5'h0, 8'h60, 3'h0, 1'h0));
    apb(1'h1, `CAB_A_REGSEL, 32'h5);
    chkr(`CAB_A_REGDATA, 32'h60);
    exe(ins(OP_COMPARE_IMMEDIATE, 5'h5, 5'h0, 8'h61, 3'h0, 1'h0));
    chkr(`CAB_A_FLAGS, 32'h35);
    chkr(`CAB_A_REGDATA, 32'h60);
    $display("io test done");
    chkr(8'h1C, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("bus test done");
    testDone();
  end
endmodule

// ===== tb/cab_exec_core_sva.sv
// Port checker for the execution core
`timescale 1ns/100ps
`include "cab_consts.svh"
module cab_exec_core_sva
(
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  ioAddr,
  input wire logic [7:0]  ioWrData,
  input wire logic [7:0]  ioWrMask,
  input wire logic        ioWrEn,
  input wire logic        ioRdEn,
  input wire logic [7:0]  ioRdData
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic instrTaken_reg;
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      instrTaken_reg <= 1'h0;
    else
      instrTaken_reg <= psel && penable && pready && pwrite && paddr == `CAB_A_INSTR;
  sequence s_wait;
    !pready ##1 pready;
  endsequence
  property p_wait; psel && $rose(penable) |-> s_wait; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  property p_strb; ioWrEn || ioRdEn |-> instrTaken_reg; endproperty
  property p_once; ioWrEn || ioRdEn |=> !ioWrEn && !ioRdEn; endproperty
  property p_bit; ioWrEn && ioWrMask != 8'hFF |-> $onehot(ioWrMask) && ioAddr inside {[8'h20:8'h3F]}; endproperty
  property p_ioaddr; ioWrEn || ioRdEn |-> ioAddr >= `CAB_IO_OFS; endproperty
  // Peripherals may latch the address late, so it must not wander
  property p_hold; !instrTaken_reg |-> $stable(ioAddr); endproperty
  a_wait: assert property (p_wait) else $error("pready not after one wait state");
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  a_err: assert property (p_err) else $error("pslverr without pready or zero data");
  a_strb: assert property (p_strb) else $error("strobe outside first busy cycle");
  a_once: assert property (p_once) else $error("strobe longer than one cycle");
  a_bit: assert property (p_bit) else $error("bit write outside low range");
  a_ioaddr: assert property (p_ioaddr) else $error("peripheral address below offset");
  a_hold: assert property (p_hold) else $error("address moved between instructions");
endmodule
bind cab_exec_core cab_exec_core_sva i_sva (.clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
  .pready, .pslverr, .ioAddr, .ioWrData, .ioWrMask, .ioWrEn, .ioRdEn, .ioRdData);

// ===== tb/cab_io_model.sv
// Peripheral register space model seen by the core
`timescale 1ns/100ps
module cab_io_model
(
  input  wire logic       clk,
  input  wire logic [7:0] ioAddr,
  input  wire logic [7:0] ioWrData,
  input  wire logic [7:0] ioWrMask,
  input  wire logic       ioWrEn,
  input  wire logic       ioRdEn,
  output wire logic [7:0] ioRdData
);
  logic [7:0] mem [256];
  logic [7:0] last;
  initial
  begin
    foreach (mem[i])
      mem[i] = i[7:0];
    last = 8'h0;
  end
  always @(posedge clk)
    if (ioWrEn)
      mem[ioAddr] <= (mem[ioAddr] & ~ioWrMask) | (ioWrData & ioWrMask);
  always @(posedge clk)
    if (ioRdEn)
      last <= mem[ioAddr];
  // Idle bus shows a moving value so a late sample is caught
  assign ioRdData = ioRdEn ? mem[ioAddr] : ~last;
endmodule
